// ==== core/tpp_map.svh ====
`ifndef TPP_MAP_SVH
`define TPP_MAP_SVH
// Instruction codes, 4-bit instruction register
`define TPP_IR_WIDTH 4
`define TPP_IR_RESET 4'hC
`define TPP_IR_IDCODE 4'h1
`define TPP_IR_BYPASS 4'hF
`define TPP_OP_DEV_RESET 4'hC
`define TPP_OP_UNLOCK 4'h4
`define TPP_OP_COMMAND 4'h5
`define TPP_OP_PAGELOAD 4'h6
// Data register widths
`define TPP_UNLOCK_WIDTH 16
`define TPP_CMD_WIDTH 15
`define TPP_BYTE_WIDTH 8
// Unlock signature and reset values
`define TPP_SIGNATURE 16'hA370
`define TPP_UNLOCK_RESET 16'h0000
`define TPP_CMD_RESET 15'h0000
// Page buffer write must finish inside this many test clocks
`define TPP_PAGE_WRITE_TCK 11
// Chip clocks from reset low to disable bit clear
`define TPP_DISABLE_CLEAR_CLKS 2
`endif

// ==== core/tpp_pkg.sv ====
package tpp_pkg;
	// Test access port controller states
	typedef enum logic [3:0] {
		TPP_TLR, TPP_RTI, TPP_SEL_DR, TPP_CAP_DR, TPP_SH_DR, TPP_EX1_DR,
		TPP_PA_DR, TPP_EX2_DR, TPP_UPD_DR, TPP_SEL_IR, TPP_CAP_IR,
		TPP_SH_IR, TPP_EX1_IR, TPP_PA_IR, TPP_EX2_IR, TPP_UPD_IR
	} tpp_tap_state_t;
	// Page buffer write request
	typedef struct packed {
		logic high;
		logic [7:0] addr;
		logic [7:0] data;
	} tpp_page_wr_t;
endpackage : tpp_pkg

// ==== core/tpp_fifo_if.sv ====
`timescale 1ns/10ps
interface tpp_fifo_if #(parameter int WIDTH = 17);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : tpp_fifo_if

// ==== core/tpp_fifo.sv ====
`timescale 1ns/10ps
module tpp_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	tpp_fifo_if.snk in_port,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	// Handshake terms; full stalls the writer
	assign in_port.ready = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != '0);
	assign push = in_port.valid && in_port.ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_q[rd_q];

	// Storage, no reset needed on data
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_port.data;
		end
	end

	// Pointers and fill count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : tpp_fifo

// ==== core/tpp_port.sv ====
`timescale 1ns/10ps
`include "tpp_map.svh"
module tpp_port #(
	parameter int FIFO_DEPTH = 4
) (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic TCK,
	input wire logic TMS,
	input wire logic TDI,
	output logic TDO,
	output logic TDO_OE,
	input wire logic EXT_RESETN,
	input wire logic ENABLE_FUSE,
	input wire logic DISABLE_SET,
	output logic DISABLE_BIT,
	output logic DEVICE_RESET,
	output logic PROG_MODE,
	output logic [14:0] CMD_OUT,
	output logic CMD_APPLY,
	output logic CMD_EXEC,
	input wire logic [14:0] CMD_RESULT,
	input wire logic [7:0] PAGE_ADDR_PRESET,
	input wire logic PAGE_ADDR_LOAD,
	output logic PAGE_WR_VALID,
	input wire logic PAGE_WR_READY,
	output logic PAGE_WR_HIGH,
	output logic [7:0] PAGE_WR_ADDR,
	output logic [7:0] PAGE_WR_DATA
);
	localparam int PW = $bits(tpp_pkg::tpp_page_wr_t);

	logic [1:0] tck_s_q;
	logic [1:0] tms_s_q;
	logic [1:0] tdi_s_q;
	logic [1:0] ext_s_q;
	logic tck_prev_q;
	logic tck_rise;
	logic tck_fall;
	tpp_pkg::tpp_tap_state_t st_q;
	tpp_pkg::tpp_tap_state_t st_d;
	logic [3:0] ir_sh_q;
	logic [3:0] ir_q;
	logic rst_bit_q;
	logic [15:0] unl_q;
	logic [14:0] cmd_q;
	logic unlocked_q;
	logic disable_q;
	logic [1:0] dis_cnt_q;
	logic port_on;
	logic high_q;
	logic first_q;
	logic [7:0] addr_q;
	logic [7:0] tmp_q;
	logic wr_pend_q;
	logic tdo_q;
	logic tdo_oe_q;
	logic cmd_apply_q;
	logic cmd_exec_q;
	logic exec_armed_q;
	tpp_pkg::tpp_page_wr_t fifo_out;

	tpp_fifo_if #(.WIDTH(PW)) page_if ();

	// Shift is one bit per sampled clock edge
	function automatic logic [15:0] shift16(input logic [15:0] v,
		input logic b);
		shift16 = {b, v[15:1]};
	endfunction : shift16

	// Test pins and external reset pass two flops before use
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			tck_s_q <= 2'h0;
			tms_s_q <= 2'h0;
			tdi_s_q <= 2'h0;
			ext_s_q <= 2'h3;
			tck_prev_q <= 1'b0;
		end else begin
			tck_s_q <= {tck_s_q[0], TCK};
			tms_s_q <= {tms_s_q[0], TMS};
			tdi_s_q <= {tdi_s_q[0], TDI};
			ext_s_q <= {ext_s_q[0], EXT_RESETN};
			tck_prev_q <= tck_s_q[1];
		end
	end
	assign tck_rise = tck_s_q[1] && !tck_prev_q;
	assign tck_fall = !tck_s_q[1] && tck_prev_q;

	// Disable bit: set by software, cleared by held external reset
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			disable_q <= 1'b0;
			dis_cnt_q <= 2'h0;
		end else if (!ext_s_q[1]) begin
			if (dis_cnt_q == 2'(`TPP_DISABLE_CLEAR_CLKS - 1)) begin
				disable_q <= 1'b0;
			end else begin
				dis_cnt_q <= dis_cnt_q + 2'h1;
			end
		end else begin
			dis_cnt_q <= 2'h0;
			if (DISABLE_SET) begin
				disable_q <= 1'b1;
			end
		end
	end
	assign port_on = ENABLE_FUSE && !disable_q;

	// Controller next state
	always_comb begin
		st_d = st_q;
		case (st_q)
			tpp_pkg::TPP_TLR: st_d = tms_s_q[1] ? tpp_pkg::TPP_TLR
				: tpp_pkg::TPP_RTI;
			tpp_pkg::TPP_RTI: st_d = tms_s_q[1] ? tpp_pkg::TPP_SEL_DR
				: tpp_pkg::TPP_RTI;
			tpp_pkg::TPP_SEL_DR: st_d = tms_s_q[1] ? tpp_pkg::TPP_SEL_IR
				: tpp_pkg::TPP_CAP_DR;
			tpp_pkg::TPP_CAP_DR: st_d = tms_s_q[1] ? tpp_pkg::TPP_EX1_DR
				: tpp_pkg::TPP_SH_DR;
			tpp_pkg::TPP_SH_DR: st_d = tms_s_q[1] ? tpp_pkg::TPP_EX1_DR
				: tpp_pkg::TPP_SH_DR;
			tpp_pkg::TPP_EX1_DR: st_d = tms_s_q[1] ? tpp_pkg::TPP_UPD_DR
				: tpp_pkg::TPP_PA_DR;
			tpp_pkg::TPP_PA_DR: st_d = tms_s_q[1] ? tpp_pkg::TPP_EX2_DR
				: tpp_pkg::TPP_PA_DR;
			tpp_pkg::TPP_EX2_DR: st_d = tms_s_q[1] ? tpp_pkg::TPP_UPD_DR
				: tpp_pkg::TPP_SH_DR;
			tpp_pkg::TPP_UPD_DR: st_d = tms_s_q[1] ? tpp_pkg::TPP_SEL_DR
				: tpp_pkg::TPP_RTI;
			tpp_pkg::TPP_SEL_IR: st_d = tms_s_q[1] ? tpp_pkg::TPP_TLR
				: tpp_pkg::TPP_CAP_IR;
			tpp_pkg::TPP_CAP_IR: st_d = tms_s_q[1] ? tpp_pkg::TPP_EX1_IR
				: tpp_pkg::TPP_SH_IR;
			tpp_pkg::TPP_SH_IR: st_d = tms_s_q[1] ? tpp_pkg::TPP_EX1_IR
				: tpp_pkg::TPP_SH_IR;
			tpp_pkg::TPP_EX1_IR: st_d = tms_s_q[1] ? tpp_pkg::TPP_UPD_IR
				: tpp_pkg::TPP_PA_IR;
			tpp_pkg::TPP_PA_IR: st_d = tms_s_q[1] ? tpp_pkg::TPP_EX2_IR
				: tpp_pkg::TPP_PA_IR;
			tpp_pkg::TPP_EX2_IR: st_d = tms_s_q[1] ? tpp_pkg::TPP_UPD_IR
				: tpp_pkg::TPP_SH_IR;
			tpp_pkg::TPP_UPD_IR: st_d = tms_s_q[1] ? tpp_pkg::TPP_SEL_DR
				: tpp_pkg::TPP_RTI;
			default: st_d = tpp_pkg::TPP_TLR;
		endcase
	end

	// Controller advances on sampled test clock rise
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			st_q <= tpp_pkg::TPP_TLR;
		end else if (!port_on) begin
			st_q <= tpp_pkg::TPP_TLR;
		end else if (tck_rise) begin
			st_q <= st_d;
		end
	end

	// Instruction register, LSB first; device reset leaves it alone
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			ir_sh_q <= 4'h0;
			ir_q <= `TPP_IR_RESET;
		end else if (!port_on || st_q == tpp_pkg::TPP_TLR) begin
			ir_q <= `TPP_IR_RESET;
		end else if (tck_rise) begin
			case (st_q)
				tpp_pkg::TPP_CAP_IR: ir_sh_q <= 4'h1;
				tpp_pkg::TPP_SH_IR: ir_sh_q <= {tdi_s_q[1],
					ir_sh_q[3:1]};
				tpp_pkg::TPP_UPD_IR: ir_q <= ir_sh_q;
				default: ir_q <= ir_q;
			endcase
		end
	end

	// One-bit reset register; its output is used unlatched
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			rst_bit_q <= 1'b0;
		end else if (tck_rise && st_q == tpp_pkg::TPP_SH_DR
			&& ir_q == `TPP_OP_DEV_RESET) begin
			rst_bit_q <= tdi_s_q[1];
		end
	end
	assign DEVICE_RESET = rst_bit_q || !ext_s_q[1];

	// Unlock register and programming mode
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			unl_q <= `TPP_UNLOCK_RESET;
			unlocked_q <= 1'b0;
		end else if (tck_rise && ir_q == `TPP_OP_UNLOCK) begin
			if (st_q == tpp_pkg::TPP_SH_DR) begin
				unl_q <= shift16(unl_q, tdi_s_q[1]);
			end else if (st_q == tpp_pkg::TPP_UPD_DR) begin
				unlocked_q <= (unl_q == `TPP_SIGNATURE);
			end
		end
	end
	assign PROG_MODE = unlocked_q;

	// Command register; page-load shifts only its low byte
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			cmd_q <= `TPP_CMD_RESET;
		end else if (tck_rise) begin
			if (ir_q == `TPP_OP_COMMAND) begin
				if (st_q == tpp_pkg::TPP_CAP_DR) begin
					cmd_q <= CMD_RESULT;
				end else if (st_q == tpp_pkg::TPP_SH_DR) begin
					cmd_q <= {tdi_s_q[1], cmd_q[14:1]};
				end
			end else if (ir_q == `TPP_OP_PAGELOAD
				&& st_q == tpp_pkg::TPP_SH_DR) begin
				cmd_q[7:0] <= {tdi_s_q[1], cmd_q[7:1]};
			end
		end
	end

	// Apply on update, execute pulse on following idle
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			CMD_OUT <= 15'h0000;
			cmd_apply_q <= 1'b0;
			cmd_exec_q <= 1'b0;
			exec_armed_q <= 1'b0;
		end else begin
			cmd_apply_q <= 1'b0;
			cmd_exec_q <= 1'b0;
			if (tck_rise && ir_q == `TPP_OP_COMMAND && unlocked_q
				&& st_q == tpp_pkg::TPP_UPD_DR) begin
				CMD_OUT <= cmd_q;
				cmd_apply_q <= 1'b1;
				exec_armed_q <= 1'b1;
			end else if (tck_rise && st_q == tpp_pkg::TPP_RTI
				&& exec_armed_q) begin
				cmd_exec_q <= 1'b1;
				exec_armed_q <= 1'b0;
			end else if (st_q != tpp_pkg::TPP_RTI
				&& st_q != tpp_pkg::TPP_UPD_DR) begin
				exec_armed_q <= 1'b0;
			end
		end
	end
	assign CMD_APPLY = cmd_apply_q;
	assign CMD_EXEC = cmd_exec_q;

	// Page load: alternate bytes, pre-increment except first
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			high_q <= 1'b0;
			first_q <= 1'b1;
			addr_q <= 8'h00;
			tmp_q <= 8'h00;
			wr_pend_q <= 1'b0;
		end else begin
			// Pending byte leaves as soon as the queue has room
			if (wr_pend_q && page_if.ready) begin
				wr_pend_q <= 1'b0;
			end
			if (PAGE_ADDR_LOAD) begin
				addr_q <= PAGE_ADDR_PRESET;
			end
			if (ir_q != `TPP_OP_PAGELOAD) begin
				high_q <= 1'b0;
				first_q <= 1'b1;
			end else if (tck_rise && st_q == tpp_pkg::TPP_UPD_DR
				&& unlocked_q && !wr_pend_q) begin
				tmp_q <= cmd_q[7:0];
				wr_pend_q <= 1'b1;
				high_q <= !high_q;
				if (!high_q && !first_q) begin
					addr_q <= addr_q + 8'h01;
				end
				first_q <= 1'b0;
			end
		end
	end

	// Page writes queue; a load while the byte is still pending is dropped, so a buffer stalled past the queue plus one loses bytes
	assign page_if.valid = wr_pend_q;
	assign page_if.data = {!high_q, addr_q, tmp_q};

	tpp_fifo #(.WIDTH(PW), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(CLK),
		.rst_n(RESETN),
		.in_port(page_if),
		.out_valid(PAGE_WR_VALID),
		.out_ready(PAGE_WR_READY),
		.out_data(fifo_out)
	);
	assign PAGE_WR_HIGH = fifo_out.high;
	assign PAGE_WR_ADDR = fifo_out.addr;
	assign PAGE_WR_DATA = fifo_out.data;

	// Data out changes on falling test clock, LSB first
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			tdo_q <= 1'b0;
			tdo_oe_q <= 1'b0;
		end else if (!port_on) begin
			// Release at once; no test clock may follow the switch-off
			tdo_oe_q <= 1'b0;
		end else if (tck_fall) begin
			tdo_oe_q <= (st_q == tpp_pkg::TPP_SH_DR)
				|| (st_q == tpp_pkg::TPP_SH_IR);
			if (st_q == tpp_pkg::TPP_SH_IR) begin
				tdo_q <= ir_sh_q[0];
			end else begin
				case (ir_q)
					`TPP_OP_DEV_RESET: tdo_q <= rst_bit_q;
					`TPP_OP_UNLOCK: tdo_q <= unl_q[0];
					default: tdo_q <= cmd_q[0];
				endcase
			end
		end
	end
	assign TDO = tdo_q;
	assign TDO_OE = tdo_oe_q;
	assign DISABLE_BIT = disable_q;
endmodule : tpp_port

// ==== verification/tpp_port_properties.sv ====
`timescale 1ns/10ps
module tpp_port_chk (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic TDO_OE,
	input wire logic EXT_RESETN,
	input wire logic ENABLE_FUSE,
	input wire logic DISABLE_BIT,
	input wire logic DEVICE_RESET,
	input wire logic PROG_MODE,
	input wire logic [14:0] CMD_OUT,
	input wire logic CMD_APPLY,
	input wire logic CMD_EXEC,
	input wire logic PAGE_WR_VALID,
	input wire logic PAGE_WR_READY,
	input wire logic PAGE_WR_HIGH,
	input wire logic [7:0] PAGE_WR_ADDR,
	input wire logic [7:0] PAGE_WR_DATA
);
	logic pend_q;
	logic lo_q;
	logic [7:0] la_q;
	logic take;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);
	assign take = PAGE_WR_VALID && PAGE_WR_READY;
	// Applied command still waiting for its execute clock
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) pend_q <= 1'b0;
		else if (CMD_APPLY) pend_q <= 1'b1;
		else if (CMD_EXEC) pend_q <= 1'b0;
	end
	// Last accepted byte was a low byte, and its address
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) lo_q <= 1'b0;
		else if (take) lo_q <= !PAGE_WR_HIGH;
	end
	always_ff @(posedge CLK) begin
		if (take) la_q <= PAGE_WR_ADDR;
	end
	// Margins allow for the two-flop pin synchronisers
	property p_dis_clear;
		(!EXT_RESETN) [*7] |-> !DISABLE_BIT;
	endproperty
	a_dis_clear: assert property (p_dis_clear)
		else $error("disable bit not cleared");
	property p_port_off;
		(!ENABLE_FUSE || DISABLE_BIT) [*8] |-> !TDO_OE;
	endproperty
	a_port_off: assert property (p_port_off)
		else $error("port active while off");
	property p_ext_reset;
		(!EXT_RESETN) [*4] |-> DEVICE_RESET;
	endproperty
	a_ext_reset: assert property (p_ext_reset)
		else $error("device not held in reset");
	property p_locked;
		!PROG_MODE |-> !CMD_APPLY && !$rose(PAGE_WR_VALID);
	endproperty
	a_locked: assert property (p_locked)
		else $error("command taken while locked");
	property p_cmd_change;
		$changed(CMD_OUT) |-> CMD_APPLY;
	endproperty
	a_cmd_change: assert property (p_cmd_change)
		else $error("command changed without apply");
	property p_exec;
		CMD_EXEC |-> pend_q ##1 !CMD_EXEC;
	endproperty
	a_exec: assert property (p_exec)
		else $error("execute pulse without command");
	property p_pair;
		take && PAGE_WR_HIGH |-> lo_q && PAGE_WR_ADDR == la_q;
	endproperty
	a_pair: assert property (p_pair)
		else $error("high byte not paired with low");
	property p_hold;
		PAGE_WR_VALID && !PAGE_WR_READY |=> PAGE_WR_VALID
			&& $stable({PAGE_WR_HIGH, PAGE_WR_ADDR, PAGE_WR_DATA});
	endproperty
	a_hold: assert property (p_hold)
		else $error("page write dropped while stalled");
	c_exec: cover property (CMD_EXEC);
	c_high: cover property (take && PAGE_WR_HIGH);
	c_reset: cover property (DEVICE_RESET && EXT_RESETN);
endmodule : tpp_port_chk
bind tpp_port tpp_port_chk u_chk (.CLK, .RESETN, .TDO_OE, .EXT_RESETN,
	.ENABLE_FUSE, .DISABLE_BIT, .DEVICE_RESET, .PROG_MODE, .CMD_OUT,
	.CMD_APPLY, .CMD_EXEC, .PAGE_WR_VALID, .PAGE_WR_READY, .PAGE_WR_HIGH,
	.PAGE_WR_ADDR, .PAGE_WR_DATA);

// ==== verification/tpp_programmer.sv ====
`timescale 1ns/10ps
module tpp_programmer (
	input wire logic CLK,
	input wire logic TDO,
	output logic TCK,
	output logic TMS,
	output logic TDI
);
	logic tdo_s;
	initial begin
		TCK = 1'b0;
		TMS = 1'b1;
		TDI = 1'b0;
	end
	// One test clock of 320 ns; only test pins are used
	task automatic tick(input logic tms, input logic tdi);
		@(negedge CLK);
		TMS = tms;
		TDI = tdi;
		repeat (3) @(negedge CLK);
		TCK = 1'b1;
		repeat (4) @(negedge CLK);
		tdo_s = TDO;
		TCK = 1'b0;
		TDI = ~tdi; // Stale data never looks valid
	endtask : tick
	// Through Test-Logic-Reset into idle
	task automatic to_idle();
		repeat (5) tick(1'b1, 1'b0);
		tick(1'b0, 1'b0);
	endtask : to_idle
	// Scan n bits LSB first, then one clock inside idle
	task automatic shift(input logic ir, input logic [15:0] v,
		input int n, output logic [15:0] o);
		o = 16'h0000;
		tick(1'b1, 1'b0);
		if (ir) tick(1'b1, 1'b0);
		tick(1'b0, 1'b0);
		tick(1'b0, 1'b0);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, v[i]);
			o[i] = tdo_s;
		end
		tick(1'b1, 1'b0);
		tick(1'b0, 1'b0);
		tick(1'b0, 1'b0);
	endtask : shift
endmodule : tpp_programmer

// ==== verification/tpp_port_tb_top.sv ====
`timescale 1ns/10ps
`include "tpp_map.svh"
module tpp_port_tb_top;
	logic CLK = 1'b0;
	logic RESETN = 1'b0;
	logic TCK, TMS, TDI, TDO, TDO_OE;
	logic EXT_RESETN = 1'b1;
	logic ENABLE_FUSE = 1'b0;
	logic DISABLE_SET = 1'b0;
	logic DISABLE_BIT, DEVICE_RESET, PROG_MODE, CMD_APPLY, CMD_EXEC;
	logic [14:0] CMD_OUT;
	logic [14:0] CMD_RESULT = 15'h0000;
	logic [7:0] PAGE_ADDR_PRESET = 8'h00;
	logic PAGE_ADDR_LOAD = 1'b0;
	logic PAGE_WR_READY = 1'b0;
	logic PAGE_WR_VALID, PAGE_WR_HIGH;
	logic [7:0] PAGE_WR_ADDR, PAGE_WR_DATA;
	logic [15:0] o, v;
	logic [16:0] got[$];
	logic [16:0] exp_q[$];
	logic rdy_en = 1'b0;
	int n_errors = 0;
	int n_checks = 0;
	int n_exec = 0;
	int seed = 32'hD0E2E1EA;
	always #20 CLK = ~CLK;
	tpp_port #(.FIFO_DEPTH(4)) DUT (.CLK, .RESETN, .TCK, .TMS, .TDI, .TDO,
		.TDO_OE, .EXT_RESETN, .ENABLE_FUSE, .DISABLE_SET, .DISABLE_BIT,
		.DEVICE_RESET, .PROG_MODE, .CMD_OUT, .CMD_APPLY, .CMD_EXEC,
		.CMD_RESULT, .PAGE_ADDR_PRESET, .PAGE_ADDR_LOAD, .PAGE_WR_VALID,
		.PAGE_WR_READY, .PAGE_WR_HIGH, .PAGE_WR_ADDR, .PAGE_WR_DATA);
	tpp_programmer prog (.CLK, .TDO, .TCK, .TMS, .TDI);
	// Count execute pulses, collect accepted page writes
	always @(posedge CLK) begin
		if (CMD_EXEC === 1'b1) n_exec <= n_exec + 1;
		if (PAGE_WR_VALID === 1'b1 && PAGE_WR_READY)
			got.push_back({PAGE_WR_HIGH, PAGE_WR_ADDR, PAGE_WR_DATA});
	end
	// Memory side stalls at random once enabled
	always @(negedge CLK) PAGE_WR_READY <= rdy_en & 1'($random(seed));
	task automatic chk(input logic [16:0] g, input logic [16:0] e);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic ir_dr(input logic [3:0] ir, input logic [15:0] d, int n);
		prog.shift(1'b1, {12'h000, ir}, 4, o);
		prog.shift(1'b0, d, n, o);
	endtask : ir_dr
	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : report_and_stop
	// Whole run needs well under a millisecond
	initial begin
		#1000000;
		n_errors++;
		report_and_stop();
	end
	initial begin
		repeat (8) @(negedge CLK);
		RESETN = 1'b1;
		repeat (4) @(negedge CLK);
		chk(PROG_MODE, 1'b0);
		// Fuse clear, then disable set: signature must not take
		ir_dr(`TPP_OP_UNLOCK, `TPP_SIGNATURE, 16);
		chk(PROG_MODE, 1'b0);
		ENABLE_FUSE = 1'b1;
		DISABLE_SET = 1'b1;
		@(negedge CLK);
		DISABLE_SET = 1'b0;
		ir_dr(`TPP_OP_UNLOCK, `TPP_SIGNATURE, 16);
		chk(PROG_MODE, 1'b0);
		EXT_RESETN = 1'b0;
		repeat (10) @(negedge CLK);
		chk(DISABLE_BIT, 1'b0);
		EXT_RESETN = 1'b1;
		prog.to_idle();
		// Still locked: command ignored, no execute clock
		ir_dr(`TPP_OP_COMMAND, 16'h1234, 15);
		chk(CMD_OUT, 15'h0000);
		chk(17'(n_exec), 17'h00000);
		// Reset bit holds the device while it is one
		ir_dr(`TPP_OP_DEV_RESET, 16'h0001, 1);
		chk(DEVICE_RESET, 1'b1);
		prog.shift(1'b0, 16'h0000, 1, o);
		chk(DEVICE_RESET, 1'b0);
		// Single-bit near misses of the signature, and one random value, are refused
		for (int k = 0; k < 17; k++) begin
			v = (k < 16) ? `TPP_SIGNATURE ^ (16'h0001 << k)
				: 16'($random(seed));
			ir_dr(`TPP_OP_UNLOCK, v == `TPP_SIGNATURE ? 16'h0000 : v, 16);
			chk(PROG_MODE, 1'b0);
		end
		ir_dr(`TPP_OP_UNLOCK, `TPP_SIGNATURE, 16);
		chk(PROG_MODE, 1'b1);
		// Commands return the result captured before them
		for (int k = 0; k < 4; k++) begin
			CMD_RESULT = k == 0 ? 15'h7FFF : 15'($random(seed));
			v = k == 1 ? 16'h7FFF : {1'b0, 15'($random(seed))};
			ir_dr(`TPP_OP_COMMAND, v, 15);
			chk(o[14:0], CMD_RESULT);
			chk(CMD_OUT, v[14:0]);
			chk(17'(n_exec), 17'(k + 1));
		end
		// Five page loads into a stalled queue of four; the fifth waits
		PAGE_ADDR_PRESET = 8'($random(seed));
		PAGE_ADDR_LOAD = 1'b1;
		prog.shift(1'b1, {12'h000, `TPP_OP_PAGELOAD}, 4, o);
		PAGE_ADDR_LOAD = 1'b0;
		for (int j = 0; j < 5; j++) begin
			v = 16'($random(seed)) & 16'h00FF;
			prog.shift(1'b0, v, 8, o);
			if (j == 0) chk(PAGE_WR_VALID, 1'b1);
			exp_q.push_back({j[0], 8'(PAGE_ADDR_PRESET + j / 2), v[7:0]});
		end
		rdy_en = 1'b1;
		for (int t = 0; t < 400 && got.size() < 5; t++) @(negedge CLK);
		repeat (40) @(negedge CLK);
		chk(17'(got.size()), 17'h00005);
		foreach (exp_q[i]) chk(got[i], exp_q[i]);
		report_and_stop();
	end
endmodule : tpp_port_tb_top
